// ===== design/sap_pkg.sv
package sap_pkg;
  // serial data format codes
  localparam logic [1:0] FMT_LJ = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_TDM = 2'h2;
  localparam logic [1:0] FMT_RSVD = 2'h3;
  // operating mode codes
  localparam logic [1:0] OP_SSM = 2'h0;
  localparam logic [1:0] OP_DSM = 2'h1;
  localparam logic [1:0] OP_QSM = 2'h2;
  localparam logic [1:0] OP_SLAVE = 2'h3;
  // register map, byte addresses
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  // mode control fields
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_OP_LSB = 2;
  localparam int CTRL_DIV_LSB = 4;
  localparam int CTRL_CPEN_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_00bf;
  // status fields
  localparam int STAT_SPEED_LSB = 0;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_MASTER_BIT = 4;
  localparam int STAT_RATIO_LSB = 16;
  // frame geometry
  localparam int SAMPLE_BITS = 24;
  localparam int SLOT_BITS = 32;
  localparam int TDM_SLOTS = 4;
  localparam logic [7:0] LJ_LAST_BIT = 8'h3f;
  localparam logic [7:0] TDM_LAST_BIT = 8'hff;
  localparam logic [8:0] POS_SAT = 9'h1ff;
  // master bit clock half period in core clocks, per speed
  localparam logic [3:0] HALF_SSM = 4'h4;
  localparam logic [3:0] HALF_DSM = 4'h2;
  localparam logic [3:0] HALF_QSM = 4'h1;
  // latest start of audio after reset release, in core clocks
  localparam int MAX_START_CYCLES = 524288;
  localparam logic [11:0] RATIO_SAT = 12'hfff;

  typedef enum logic [2:0] {
    SPD_SINGLE = 3'b001,
    SPD_DOUBLE = 3'b010,
    SPD_QUAD = 3'b100
  } sap_speed_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } sap_state_t;
endpackage : sap_pkg

// ===== design/sap_port.sv
module sap_port import sap_pkg::*; #(
  parameter int START_WAIT = 1024,
  parameter int THR_SINGLE = 192,
  parameter int THR_DOUBLE = 96
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_select_hi,
  input wire logic op_select_lo,
  input wire logic format_select_hi,
  input wire logic format_select_lo,
  input wire logic clk_src_crystal,
  input wire logic crystal_in,
  output logic crystal_out,
  output logic mclk_pin_out,
  output logic mclk_pin_oe,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  input wire logic [23:0] sample_ch1,
  input wire logic [23:0] sample_ch2,
  input wire logic [23:0] sample_ch3,
  input wire logic [23:0] sample_ch4,
  output logic sample_take,
  output logic serial_out_first,
  output logic serial_out_second,
  output logic serial_out_third_complement,
  output logic serial_out_fourth
);

  // refuse settings the counters cannot serve, at elaboration
  if (START_WAIT < 1 || START_WAIT > MAX_START_CYCLES) begin : g_bad_start
    $error("START_WAIT out of range");
  end
  if (THR_DOUBLE < 1 || THR_SINGLE <= THR_DOUBLE ||
      THR_SINGLE > 4095) begin : g_bad_thr
    $error("speed thresholds out of order");
  end

  localparam logic [19:0] START_LAST = 20'(START_WAIT - 1);
  localparam logic [11:0] THR_S = 12'(THR_SINGLE);
  localparam logic [11:0] THR_D = 12'(THR_DOUBLE);

  logic [31:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic [1:0] op_pin_reg;
  logic [1:0] fmt_pin_reg;
  logic latched_reg;
  sap_state_t state_reg;
  logic [19:0] start_cnt_reg;
  logic [3:0] half_cnt_reg;
  logic m_sclk_reg;
  logic m_fclk_reg;
  logic [7:0] mbit_reg;
  logic sclk_prev_reg;
  logic fclk_prev_reg;
  logic [8:0] pos_reg;
  logic odd_reg;
  logic [23:0] sh_reg [0:TDM_SLOTS-1];
  logic [23:0] samp_in [0:TDM_SLOTS-1];
  logic take_reg;
  logic out_a_reg;
  logic out_b_reg;
  logic out_c_reg;
  logic [11:0] per_cnt_reg;
  logic [11:0] ratio_reg;
  sap_speed_t speed_reg;
  logic cpen, is_master, is_tdm, is_rsvd, is_i2s, running;
  logic [1:0] op_eff, fmt_eff, div_shift;
  logic [3:0] half_lim;
  logic [7:0] mbit_next, frame_last;
  logic sclk_cur, fclk_cur, sclk_fall, fclk_rise, fclk_fall;
  logic restart, odd_now, load_now;
  logic bit_a, bit_b;
  logic [8:0] eff_pos;
  logic [11:0] ratio_now;
  sap_speed_t master_speed;

  function automatic logic sample_bit(input logic [23:0] w,
                                      input logic [8:0] idx);
    sample_bit = (idx < 9'(SAMPLE_BITS)) ? w[5'd23 - idx[4:0]] : 1'b0;
  endfunction : sample_bit

  assign samp_in[0] = sample_ch1;
  assign samp_in[1] = sample_ch2;
  assign samp_in[2] = sample_ch3;
  assign samp_in[3] = sample_ch4;

  // strap pins are caught once, on the first edge after reset release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_pin_reg <= 2'h0;
      fmt_pin_reg <= 2'h0;
      latched_reg <= 1'b0;
    end else if (!latched_reg) begin
      op_pin_reg <= {op_select_hi, op_select_lo};
      fmt_pin_reg <= {format_select_hi, format_select_lo};
      latched_reg <= 1'b1;
    end
  end

  // pins or register; once enabled, the pins no longer matter
  assign cpen = ctrl_reg[CTRL_CPEN_BIT];
  assign op_eff = cpen ? ctrl_reg[CTRL_OP_LSB +: 2] : op_pin_reg;
  assign fmt_eff = cpen ? ctrl_reg[CTRL_FMT_LSB +: 2] : fmt_pin_reg;
  assign div_shift = ctrl_reg[CTRL_DIV_LSB +: 2];
  assign is_master = (op_eff != OP_SLAVE);
  assign is_tdm = (fmt_eff == FMT_TDM);
  assign is_i2s = (fmt_eff == FMT_I2S);
  assign is_rsvd = (fmt_eff == FMT_RSVD);
  assign running = (state_reg == ST_RUN);

  // start-up wait; bounded by the latest allowed start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_WAIT;
      start_cnt_reg <= 20'h0_0000;
    end else begin
      case (state_reg)
        ST_WAIT: begin
          if (latched_reg) begin
            start_cnt_reg <= start_cnt_reg + 20'h0_0001;
            if (start_cnt_reg == START_LAST) state_reg <= ST_RUN;
          end
        end
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_WAIT;
      endcase
    end
  end

  // master speed straight from the op code
  always_comb begin
    case (op_eff)
      OP_DSM: begin
        master_speed = SPD_DOUBLE;
        half_lim = HALF_DSM;
      end
      OP_QSM: begin
        master_speed = SPD_QUAD;
        half_lim = HALF_QSM;
      end
      default: begin
        master_speed = SPD_SINGLE;
        half_lim = HALF_SSM;
      end
    endcase
  end

  // master clock generation; frame clock moves on the bit clock fall
  assign frame_last = is_tdm ? TDM_LAST_BIT : LJ_LAST_BIT;
  assign mbit_next = (mbit_reg >= frame_last) ? 8'h00 : mbit_reg + 8'h01;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      half_cnt_reg <= 4'h0;
      m_sclk_reg <= 1'b0;
      m_fclk_reg <= 1'b0;
      mbit_reg <= 8'hff;
    end else if (!running || !is_master || is_rsvd) begin
      half_cnt_reg <= 4'h0;
      m_sclk_reg <= 1'b0;
      m_fclk_reg <= 1'b0;
      mbit_reg <= 8'hff;
    end else if (half_cnt_reg >= half_lim - 4'h1) begin
      half_cnt_reg <= 4'h0;
      m_sclk_reg <= ~m_sclk_reg;
      if (m_sclk_reg) begin
        mbit_reg <= mbit_next;
        // lj: high in first half; tdm: high for the first slot only; i2s: low in first half
        m_fclk_reg <= (mbit_next < 8'(SLOT_BITS)) ^ is_i2s;
      end
    end else begin
      half_cnt_reg <= half_cnt_reg + 4'h1;
    end
  end

  // pick own or partner clocks; inputs are already synchronous
  assign sclk_cur = is_master ? m_sclk_reg : bit_clock_in;
  assign fclk_cur = is_master ? m_fclk_reg : frame_clock_in;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_reg <= 1'b0;
      fclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_cur;
      fclk_prev_reg <= fclk_cur;
    end
  end
  assign sclk_fall = sclk_prev_reg & ~sclk_cur;
  assign fclk_rise = ~fclk_prev_reg & fclk_cur;
  assign fclk_fall = fclk_prev_reg & ~fclk_cur;
  assign odd_now = is_i2s ? ~fclk_cur : fclk_cur;
  // tdm ignores the falling frame edge
  assign restart = running && !is_rsvd &&
                   (is_tdm ? fclk_rise : (fclk_rise | fclk_fall));
  assign load_now = restart && (is_tdm || odd_now);

  // bit position within channel or frame, saturating for long frames
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pos_reg <= 9'h000;
      odd_reg <= 1'b0;
      take_reg <= 1'b0;
    end else begin
      take_reg <= load_now;
      if (!running || is_rsvd) begin
        pos_reg <= 9'h000;
      end else if (restart) begin
        pos_reg <= 9'h000;
        odd_reg <= odd_now;
      end else if (sclk_fall && pos_reg != POS_SAT) begin
        pos_reg <= pos_reg + 9'h001;
      end
    end
  end

  // one shadow word per channel, captured at frame start
  for (genvar ch = 0; ch < TDM_SLOTS; ch++) begin : g_shadow
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) sh_reg[ch] <= 24'h00_0000;
      else if (load_now) sh_reg[ch] <= samp_in[ch];
    end
  end

  // bit selection; i2s lags its frame edge by one bit clock
  always_comb begin
    eff_pos = pos_reg - {8'h00, is_i2s};
    bit_a = 1'b0;
    bit_b = 1'b0;
    if (is_tdm) begin
      // only four slots carry data; the rest of the frame stays zero
      if (pos_reg < 9'(TDM_SLOTS * SLOT_BITS))
        bit_a = sample_bit(sh_reg[pos_reg[6:5]], {4'h0, pos_reg[4:0]});
    end else if (!(is_i2s && pos_reg == 9'h000)) begin
      // past 24 bits reads zero; short channels simply stop early
      bit_a = sample_bit(odd_reg ? sh_reg[0] : sh_reg[1], eff_pos);
      bit_b = sample_bit(odd_reg ? sh_reg[2] : sh_reg[3], eff_pos);
    end
  end

  // registered data pins, one core clock behind the position
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      out_c_reg <= 1'b0;
    end else if (!running || is_rsvd) begin
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
      out_c_reg <= 1'b0;
    end else begin
      out_a_reg <= bit_a;
      out_b_reg <= is_tdm ? 1'b0 : bit_b;
      out_c_reg <= is_tdm ? ~bit_a : 1'b0;
    end
  end

  // slave speed: core clocks per frame, scaled by the divider
  assign ratio_now = per_cnt_reg >> div_shift;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      per_cnt_reg <= 12'h000;
      ratio_reg <= 12'h000;
      speed_reg <= SPD_SINGLE;
    end else if (is_master) begin
      per_cnt_reg <= 12'h000;
      speed_reg <= master_speed;
    end else if (fclk_rise) begin
      per_cnt_reg <= 12'h001;
      ratio_reg <= ratio_now;
      if (ratio_now >= THR_S) speed_reg <= SPD_SINGLE;
      else if (ratio_now >= THR_D) speed_reg <= SPD_DOUBLE;
      else speed_reg <= SPD_QUAD;
    end else if (per_cnt_reg != RATIO_SAT) begin
      per_cnt_reg <= per_cnt_reg + 12'h001;
    end
  end

  // apb write in the access phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == ADDR_MODE_CTRL) begin
      ctrl_reg <= pwdata & CTRL_WMASK;
    end
  end

  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == ADDR_MODE_CTRL) begin
        prdata_reg <= ctrl_reg;
      end else if (paddr == ADDR_STATUS) begin
        prdata_reg <= 32'h0000_0000;
        prdata_reg[STAT_SPEED_LSB +: 3] <= speed_reg;
        prdata_reg[STAT_RUN_BIT] <= running;
        prdata_reg[STAT_MASTER_BIT] <= is_master;
        prdata_reg[STAT_RATIO_LSB +: 12] <= ratio_reg;
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = psel & penable;
  assign pslverr = psel & penable &
                   (paddr != ADDR_MODE_CTRL) & (paddr != ADDR_STATUS);

  // clock source pins; the copy is a pure buffer, no register
  assign mclk_pin_oe = clk_src_crystal;
  assign mclk_pin_out = clk_src_crystal & crystal_in;
  assign crystal_out = clk_src_crystal & ~crystal_in;
  assign bit_clock_out = m_sclk_reg;
  assign bit_clock_oe = is_master;
  assign frame_clock_out = m_fclk_reg;
  assign frame_clock_oe = is_master;
  assign sample_take = take_reg;
  assign serial_out_first = out_a_reg;
  assign serial_out_second = out_b_reg;
  assign serial_out_third_complement = out_c_reg;
  assign serial_out_fourth = 1'b0;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_tdm_complement: assert property (
    running && is_tdm && $stable(fmt_eff) |=> out_c_reg == ~out_a_reg)
    else $error("tdm complement output wrong");
  chk_reserved_quiet: assert property (
    is_rsvd && $past(is_rsvd) |-> !out_a_reg && !out_b_reg && !m_fclk_reg)
    else $error("reserved format still active");
  chk_master_drive: assert property (
    is_master |-> bit_clock_oe && frame_clock_oe)
    else $error("master not driving clocks");
  chk_slave_release: assert property (
    !is_master |-> !bit_clock_oe && !frame_clock_oe)
    else $error("slave driving clock pins");
  chk_mclk_source: assert property (
    clk_src_crystal |-> mclk_pin_oe && mclk_pin_out == crystal_in)
    else $error("crystal copy missing");
  chk_pin_ignore: assert property (
    cpen |-> fmt_eff == ctrl_reg[1:0] && op_eff == ctrl_reg[3:2])
    else $error("pins used under control port");
  chk_start_bound: assert property (
    state_reg == ST_WAIT |-> start_cnt_reg <= START_LAST)
    else $error("start-up wait overrun");
  chk_frame_restart: assert property (
    restart |=> pos_reg == 9'h000)
    else $error("frame start not honoured");
  chk_pad_zero: assert property (
    running && !is_tdm && !is_rsvd && eff_pos >= 9'd24 &&
    !(is_i2s && pos_reg == 9'h000) && $stable(fmt_eff)
    |=> !out_a_reg && !out_b_reg)
    else $error("padding bit not zero");
  chk_master_speed: assert property (
    is_master && op_eff == OP_QSM |=> speed_reg == SPD_QUAD)
    else $error("master speed decode wrong");

endmodule : sap_port

// ===== bench/sap_far_end.sv
module sap_far_end (
  input wire logic core_clk,
  input wire logic gen_en,
  input wire logic [7:0] bits_ch,
  input wire logic bclk,
  input wire logic fclk,
  input wire logic [1:0] sd,
  output logic bclk_gen,
  output logic fclk_gen,
  output logic [255:0] rx0,
  output logic [255:0] rx1,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  // half period kept above what the port can follow
  localparam int HALF = 5;
  logic [7:0] cnt_reg;
  logic [7:0] nb_reg;
  logic [255:0] w0 = '0;
  logic [255:0] w1 = '0;
  logic fprev = 1'b0;
  int idx = 0;
  int fcount = 0;
  assign frames = fcount;
  // clocks from core_clk, still at 0 while off; frame flips on bit fall
  always_ff @(posedge core_clk) begin
    if (!gen_en) begin
      cnt_reg <= 8'h00;
      nb_reg <= 8'h00;
      bclk_gen <= 1'b0;
      fclk_gen <= 1'b0;
    end else if (cnt_reg == 8'(HALF - 1)) begin
      cnt_reg <= 8'h00;
      bclk_gen <= ~bclk_gen;
      if (bclk_gen && nb_reg == bits_ch - 8'h01) begin
        nb_reg <= 8'h00;
        fclk_gen <= ~fclk_gen;
      end else if (bclk_gen) begin
        nb_reg <= nb_reg + 8'h01;
      end
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // sample on bit rise; a frame rise hands over the finished window
  always @(posedge bclk) begin
    if (fclk && !fprev) begin
      rx0 = w0;
      rx1 = w1;
      w0 = '0;
      w1 = '0;
      idx = 0;
      fcount++;
    end
    if (idx < 256) begin
      w0[255-idx] = sd[0];
      w1[255-idx] = sd[1];
    end
    idx++;
    fprev = fclk;
  end
endmodule : sap_far_end

// ===== bench/adc_serial_audio_port_tb_top.sv
module adc_serial_audio_port_tb_top import sap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] S1 = 24'ha5c3e1;
  localparam logic [23:0] S2 = 24'h5a3c1e;
  localparam logic [23:0] S3 = 24'hc0ffee;
  localparam logic [23:0] S4 = 24'h123456;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] op = 2'h0;
  logic [1:0] fmt = 2'h0;
  logic clk_src = 1'b0;
  logic xtal = 1'b0;
  logic xtal_o;
  logic mclk_o;
  logic mclk_oe;
  logic bc_o;
  logic bc_oe;
  logic fc_o;
  logic fc_oe;
  logic take;
  logic [3:0] so;
  logic gen_en = 1'b0;
  logic [7:0] bits_ch = 8'd40;
  logic g_bclk;
  logic g_fclk;
  wire logic bclk = bc_oe ? bc_o : g_bclk;
  wire logic fclk = fc_oe ? fc_o : g_fclk;
  logic [255:0] rx0;
  logic [255:0] rx1;
  int frames;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] r;
  logic e;

  always #4 core_clk = ~core_clk;

  sap_port #(.START_WAIT(16)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_select_hi(op[1]), .op_select_lo(op[0]),
    .format_select_hi(fmt[1]), .format_select_lo(fmt[0]),
    .clk_src_crystal(clk_src), .crystal_in(xtal), .crystal_out(xtal_o),
    .mclk_pin_out(mclk_o), .mclk_pin_oe(mclk_oe),
    .bit_clock_in(g_bclk), .bit_clock_out(bc_o), .bit_clock_oe(bc_oe),
    .frame_clock_in(g_fclk), .frame_clock_out(fc_o),
    .frame_clock_oe(fc_oe), .sample_ch1(S1), .sample_ch2(S2),
    .sample_ch3(S3), .sample_ch4(S4), .sample_take(take),
    .serial_out_first(so[0]), .serial_out_second(so[1]),
    .serial_out_third_complement(so[2]), .serial_out_fourth(so[3])
  );

  sap_far_end far_u (
    .core_clk(core_clk), .gen_en(gen_en), .bits_ch(bits_ch),
    .bclk(bclk), .fclk(fclk), .sd(so[1:0]), .bclk_gen(g_bclk),
    .fclk_gen(g_fclk), .rx0(rx0), .rx1(rx1), .frames(frames)
  );

  task automatic chk(input logic [255:0] seen, input logic [255:0] exp,
                     input string msg);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk

  // one apb transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // a hang here is ended by the global cycle ceiling
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pins are latched only at release, so each setup needs a reset
  task automatic rst(input logic [1:0] o, input logic [1:0] f);
    rstn <= 1'b0;
    op <= o;
    fmt <= f;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : rst

  task automatic wait_frames(input int k);
    int f0;
    int n;
    f0 = frames;
    n = 0;
    while (frames < f0 + k && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 20000, 1'b1, "no frames");
  endtask : wait_frames

  // core cycles between two rises of the bit or frame clock
  task automatic per(input logic f, output int p);
    int k;
    int n;
    logic l;
    logic c;
    k = 0;
    n = 0;
    p = 0;
    l = 1'b1;
    while (k < 2 && n < 5000) begin
      @(posedge core_clk);
      c = f ? fc_o : bc_o;
      n++;
      if (k == 1) p++;
      if (c === 1'b1 && l === 1'b0) k++;
      l = c;
    end
  endtask : per

  task automatic t_speeds();
    logic [3:0] h [3] = '{HALF_SSM, HALF_DSM, HALF_QSM};
    logic [2:0] s [3] = '{SPD_SINGLE, SPD_DOUBLE, SPD_QUAD};
    int p;
    for (int i = 0; i < 3; i++) begin
      rst(2'(i), FMT_LJ);
      chk({bc_oe, fc_oe}, 2'b11, "master oe");
      per(1'b0, p);
      chk(p, 2 * int'(h[i]), "bit period");
      per(1'b1, p);
      chk(p, 128 * int'(h[i]), "frame period");
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(r[4:0], {2'b11, s[i]}, "status");
    end
    $display("test speeds done");
  endtask : t_speeds

  task automatic t_lj();
    int nt;
    rst(OP_SSM, FMT_LJ);
    wait_frames(3);
    chk(rx0, {S1, 8'h0, S2, 8'h0, 192'h0}, "lj first");
    chk(rx1, {S3, 8'h0, S4, 8'h0, 192'h0}, "lj second");
    // two frames of 512 core clocks: exactly two capture pulses
    nt = 0;
    repeat (1024) begin
      @(posedge core_clk);
      if (take === 1'b1) nt++;
    end
    chk(nt, 2, "sample take");
    $display("test lj done");
  endtask : t_lj

  task automatic t_i2s();
    rst(OP_SSM, FMT_I2S);
    wait_frames(3);
    chk(rx0[255-:64], {1'b0, S2, 8'h0, S1, 7'h0}, "i2s");
    $display("test i2s done");
  endtask : t_i2s

  task automatic t_tdm();
    int p;
    logic bad;
    rst(OP_SSM, FMT_TDM);
    wait_frames(3);
    chk(rx0, {S1, 8'h0, S2, 8'h0, S3, 8'h0, S4, 8'h0, 128'h0},
        "tdm slots");
    per(1'b1, p);
    chk(p, 256 * 2 * int'(HALF_SSM), "tdm frame");
    bad = 1'b0;
    repeat (400) begin
      @(posedge core_clk);
      if (so[2] !== ~so[0] || so[1] !== 1'b0 || so[3] !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0, "tdm outputs");
    $display("test tdm done");
  endtask : t_tdm

  task automatic t_slave();
    gen_en <= 1'b1;
    bits_ch <= 8'd40;
    rst(OP_SLAVE, FMT_LJ);
    chk({bc_oe, fc_oe}, 2'b00, "slave oe");
    wait_frames(3);
    chk(rx0[255-:80], {S1, 16'h0, S2, 16'h0}, "pad");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[27:16], r[2:0]}, {12'h320, SPD_SINGLE}, "single");
    bits_ch <= 8'd16;
    wait_frames(3);
    chk(rx0[255-:36], {S1[23:8], S2[23:8], 4'h0}, "trunc");
    apb(1'b1, ADDR_MODE_CTRL, 32'h0000_00ac);
    wait_frames(3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[27:16], r[2:0]}, {12'h050, SPD_QUAD}, "quad");
    gen_en <= 1'b0;
    $display("test slave done");
  endtask : t_slave

  task automatic t_regs();
    logic any;
    rst(OP_SSM, FMT_LJ);
    apb(1'b0, ADDR_MODE_CTRL, 32'h0);
    chk(r, CTRL_RESET, "ctrl reset");
    apb(1'b1, ADDR_MODE_CTRL, 32'h0000_008c);
    repeat (4) @(posedge core_clk);
    chk(bc_oe, 1'b0, "pins ignored");
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[STAT_MASTER_BIT], 1'b0, "status ro");
    apb(1'b0, 8'h08, 32'h0);
    chk({e, r}, {1'b1, 32'h0}, "unmapped");
    apb(1'b1, ADDR_MODE_CTRL, 32'hffff_ffff);
    apb(1'b0, ADDR_MODE_CTRL, 32'h0);
    chk(r, CTRL_WMASK, "mask");
    apb(1'b1, ADDR_MODE_CTRL, 32'h0000_0083);
    repeat (600) @(posedge core_clk);
    any = 1'b0;
    repeat (300) begin
      @(posedge core_clk);
      if ({so, fc_o} !== 5'h00) any = 1'b1;
    end
    chk(any, 1'b0, "reserved quiet");
    $display("test regs done");
  endtask : t_regs

  task automatic t_clk_src();
    clk_src <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      xtal <= 1'(i);
      @(posedge core_clk);
      #1;
      chk({mclk_oe, mclk_o, xtal_o}, {1'b1, 1'(i), 1'(1 - i)},
          "mclk copy");
    end
    clk_src <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({mclk_oe, xtal_o}, 2'b00, "mclk input");
    $display("test clock source done");
  endtask : t_clk_src

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ceiling well above the expected run of about 20k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    t_speeds();
    t_lj();
    t_i2s();
    t_tdm();
    t_slave();
    t_regs();
    t_clk_src();
    tally_and_finish();
  end
endmodule : adc_serial_audio_port_tb_top
